// ---- rtl/pa_map.vh ----
// Register map, reset values and fixed codes of the picture
// adjust and luma noise reduction stage.
// Carries its own include guard and needs no timescale.
`ifndef PA_MAP_VH
`define PA_MAP_VH

// Control port subaddresses
`define OFS_HUE        6'h20
`define OFS_BRIGHT     6'h21
`define OFS_SHARP      6'h22
`define OFS_NR_GAIN    6'h23
`define OFS_NR_THRBLK  6'h24
`define OFS_NR_MODEOFS 6'h25

// Reset values
`define RST_HUE        8'h80
`define RST_BRIGHT     8'h00
`define RST_SHARP      8'h06
`define RST_NR_GAIN    8'h00
`define RST_NR_THRBLK  8'h00
`define RST_NR_MODEOFS 8'h00

// Field positions
`define BRIGHT_MSB     6
`define SHARP_MSB      3
`define BORDER_GAIN_LSB 0
`define BLOCK_GAIN_LSB 4
`define THR_MSB        5
`define BORDER_W_BIT   6
`define BLOCK_SZ_BIT   7
`define INSEL_MSB      2
`define MODE_BIT       3
`define GRID_OFS_LSB   4

// Fixed codes
`define HUE_ZERO       8'h80
`define SHARP_NOMINAL  4'h6
`define LUMA_EXTENDED  3'h4
`define GAIN_MAX       4'h8
`define INSEL_AVG2     3'h1
`define INSEL_AVG4     3'h2
`define LAST_BIG       4'hf
`define LAST_SMALL     4'h7
`define HALF_WIDE      4'h2
`define HALF_NARROW    4'h1
`define DNR_SHIFT      3
`define SHARP_SHIFT    4
`define SCALE_SHIFT    7

// Stream buffer shape
`define FIFO_WIDTH     19
`define FIFO_DEPTH     16

`endif

// ---- rtl/pixel_fifo.v ----
// Synchronous first-in first-out buffer for the pixel stream.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module pixel_fifo
#(
    parameter WIDTH = 19,
    parameter DEPTH = 16,
    parameter AW    = 4
)
(
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    // Filling side
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    // Draining side
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);

    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
    reg [AW-1:0]    wp_q;            // Write pointer
    reg [AW-1:0]    rp_q;            // Read pointer
    reg [AW:0]      cnt_q;           // Words held
    wire            push;            // Word accepted
    wire            pop;             // Word drained

    // Full and empty come straight from the count
    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem[rp_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage has no reset; only written words are ever read
    always @(posedge clk)
    begin
        if (push)
            mem[wp_q] <= in_data;
    end

    // Pointers and count
    always @(posedge clk)
    begin
        if (rst)
        begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
            if (push & ~pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop & ~push)
                cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule // pixel_fifo

`default_nettype wire

// ---- rtl/picture_adjust_noise_reduce.v ----
// Picture adjust and block based luma noise reduction stage.
// Assumes a 4:2:2 stream, one luma and one chroma sample a word,
// all inputs synchronous to REF_CLK.
`timescale 1ns/100ps
`default_nettype none
`include "pa_map.vh"

module picture_adjust_noise_reduce
(
    // Clock and reset
    input  wire       REF_CLK,
    input  wire       SYS_RST,
    // Control port
    input  wire [5:0] REG_ADDR,
    input  wire [7:0] REG_WDATA,
    input  wire       REG_WR,
    input  wire       REG_RD,
    output reg  [7:0] REG_RDATA,
    // Mode controls held elsewhere
    input  wire [2:0] LUMA_FILTER_SELECT,
    input  wire       SHARPNESS_FILTER_ENABLE,
    input  wire [7:0] LUMA_SCALE_VALUE,
    // Pixel stream in
    input  wire [7:0] PIX_Y,
    input  wire [7:0] PIX_C,
    input  wire       PIX_LINE,
    input  wire       PIX_FIELD,
    input  wire       PIX_ACTIVE,
    input  wire       PIX_VALID,
    output wire       PIX_READY,
    // Pixel stream out
    output reg  [7:0] OUT_Y,
    output reg  [7:0] OUT_C,
    output reg  [7:0] OUT_HUE_PHASE,
    output reg        OUT_ACTIVE,
    output reg        OUT_VALID,
    input  wire       OUT_READY,
    // Effective sharpness response
    output reg  [3:0] SHARP_CODE,
    output reg        SHARP_ON
);

    // Saturate a signed sum to an unsigned byte
    function [7:0] sat8;
        input signed [12:0] v;
        begin
            if (v < 13'sd0)
                sat8 = 8'h00;
            else if (v > 13'sd255)
                sat8 = 8'hff;
            else
                sat8 = v[7:0];
        end
    endfunction

    // Detail band of the luma, the part that gets cored
    function signed [9:0] band;
        input [2:0] sel;
        input [7:0] y0;
        input [7:0] y1;
        input [7:0] y2;
        input [7:0] y3;
        input [7:0] y4;
        reg   [9:0] s2;
        reg   [9:0] s4;
        begin
            s2 = {2'b00, y1} + {2'b00, y2};
            s4 = s2 + {2'b00, y3} + {2'b00, y4};
            case (sel)
                `INSEL_AVG2:
                    band = $signed({2'b00, y0}) - $signed({1'b0, s2[9:1]});
                `INSEL_AVG4:
                    band = $signed({2'b00, y0}) - $signed({2'b00, s4[9:2]});
                default:
                    // Widest band: plain sample difference
                    band = $signed({2'b00, y0}) - $signed({2'b00, y1});
            endcase
        end
    endfunction

    // True when a grid position lies in the border strip
    function edge_of;
        input [3:0] pos;
        input       big;
        input       wide;
        reg   [3:0] p;
        reg   [3:0] last;
        reg   [3:0] half;
        begin
            p    = big ? pos : {1'b0, pos[2:0]};
            last = big ? `LAST_BIG : `LAST_SMALL;
            half = wide ? `HALF_WIDE : `HALF_NARROW;
            edge_of = (p < half) || (p > (last - half));
        end
    endfunction

    // Control registers
    reg [7:0] hue_q;        // Hue phase offset
    reg [7:0] bright_q;     // Brightness setup
    reg [7:0] sharp_q;      // Sharpness response
    reg [7:0] gain_q;       // Border and block coring gains
    reg [7:0] thrblk_q;     // Threshold, border width, block size
    reg [7:0] modeofs_q;    // Input filter, mode, grid offset

    // Field views
    wire [6:0] brightness_value       = bright_q[`BRIGHT_MSB:0];
    wire [3:0] sharpness_code         = sharp_q[`SHARP_MSB:0];
    wire [3:0] border_coring_gain     = gain_q[`BORDER_GAIN_LSB+3:`BORDER_GAIN_LSB];
    wire [3:0] block_coring_gain      = gain_q[`BLOCK_GAIN_LSB+3:`BLOCK_GAIN_LSB];
    wire [5:0] noise_threshold        = thrblk_q[`THR_MSB:0];
    wire       border_width_sel       = thrblk_q[`BORDER_W_BIT];
    wire       block_size_sel         = thrblk_q[`BLOCK_SZ_BIT];
    wire [2:0] noise_input_filter_sel = modeofs_q[`INSEL_MSB:0];
    wire       noise_mode_sel         = modeofs_q[`MODE_BIT];
    wire [3:0] block_grid_offset      = modeofs_q[`GRID_OFS_LSB+3:`GRID_OFS_LSB];

    // Register writes; all six hold what software wrote, and the
    // upper sharpness bits are kept so a read shows them back
    always @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            hue_q     <= `RST_HUE;
            bright_q  <= `RST_BRIGHT;
            sharp_q   <= `RST_SHARP;
            gain_q    <= `RST_NR_GAIN;
            thrblk_q  <= `RST_NR_THRBLK;
            modeofs_q <= `RST_NR_MODEOFS;
        end
        else if (REG_WR)
        begin
            case (REG_ADDR)
                `OFS_HUE:        hue_q     <= REG_WDATA;
                `OFS_BRIGHT:     bright_q  <= REG_WDATA;
                `OFS_SHARP:      sharp_q   <= REG_WDATA;
                `OFS_NR_GAIN:    gain_q    <= REG_WDATA;
                `OFS_NR_THRBLK:  thrblk_q  <= REG_WDATA;
                `OFS_NR_MODEOFS: modeofs_q <= REG_WDATA;
                default:         hue_q     <= hue_q;
            endcase
        end
    end

    // Register reads answer one cycle after the strobe;
    // unmapped subaddresses read as zero
    always @(posedge REF_CLK)
    begin
        if (SYS_RST)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
        begin
            case (REG_ADDR)
                `OFS_HUE:        REG_RDATA <= hue_q;
                `OFS_BRIGHT:     REG_RDATA <= bright_q;
                `OFS_SHARP:      REG_RDATA <= sharp_q;
                `OFS_NR_GAIN:    REG_RDATA <= gain_q;
                `OFS_NR_THRBLK:  REG_RDATA <= thrblk_q;
                `OFS_NR_MODEOFS: REG_RDATA <= modeofs_q;
                default:         REG_RDATA <= 8'h00;
            endcase
        end
    end

    // Input buffer; it absorbs stalls on the output side, and
    // when it fills PIX_READY drops back to the source
    wire [`FIFO_WIDTH-1:0] f_in;   // Packed input word
    wire [`FIFO_WIDTH-1:0] f_out;  // Packed buffered word
    wire                   f_valid; // Buffered word present
    wire                   take;    // Word consumed this cycle

    assign f_in = {PIX_FIELD, PIX_LINE, PIX_ACTIVE, PIX_C, PIX_Y};

    pixel_fifo
    #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (4)
    )
    u_fifo
    (
        .clk       (REF_CLK),
        .rst       (SYS_RST),
        .in_data   (f_in),
        .in_valid  (PIX_VALID),
        .in_ready  (PIX_READY),
        .out_data  (f_out),
        .out_valid (f_valid),
        .out_ready (take)
    );

    // Unpacked buffered word
    wire [7:0] y0     = f_out[7:0];
    wire [7:0] c0     = f_out[15:8];
    wire       act0   = f_out[16];
    wire       line0  = f_out[17];
    wire       field0 = f_out[18];

    // Drain when the output register is free or being emptied
    assign take = f_valid & (OUT_READY | ~OUT_VALID);

    // Luma history and block grid counters
    reg [7:0] y1_q;    // Previous luma
    reg [7:0] y2_q;    // Two back
    reg [7:0] y3_q;    // Three back
    reg [7:0] y4_q;    // Four back
    reg [3:0] hcnt_q;  // Pixel count within line, wraps
    reg [3:0] vcnt_q;  // Line count within field, wraps

    // Current pixel and line positions; a line or field flag
    // marks the word that is position zero
    wire [3:0] hnow = line0 ? 4'h0 : hcnt_q;
    wire [3:0] vnow = field0 ? 4'h0 : (line0 ? vcnt_q + 4'h1 : vcnt_q);

    // Grid shifted against the data by whole pixels
    wire [3:0] hpos = hnow + block_grid_offset;

    // Border strip test in both directions
    wire in_border = edge_of(hpos, block_size_sel, border_width_sel) |
                     edge_of(vnow, block_size_sel, border_width_sel);

    // Gain in force at this pixel, limited to the top step
    wire [3:0] g_raw = in_border ? border_coring_gain : block_coring_gain;
    wire [3:0] gain  = (g_raw > `GAIN_MAX) ? `GAIN_MAX : g_raw;

    // Detail band and its magnitude
    wire signed [9:0] hp  = band(noise_input_filter_sel, y0, y1_q, y2_q, y3_q, y4_q);
    wire        [9:0] mag = hp[9] ? (10'h000 - hp) : hp;

    // Noise lies below the threshold, detail above it
    wire below = (mag < {4'h0, noise_threshold});
    wire above = (mag > {4'h0, noise_threshold});

    // Scaled band; eighths in reduction mode, sixteenths when
    // sharpening, so a gain of 8 reaches 1 or 0.5
    wire signed [14:0] prod = hp * $signed({1'b0, gain});
    wire signed [14:0] cut  = prod >>> `DNR_SHIFT;
    wire signed [14:0] lift = prod >>> `SHARP_SHIFT;

    // Cored luma
    reg signed [12:0] nr_sum;  // Luma after coring, unclipped
    always @*
    begin
        nr_sum = $signed({5'h00, y0});
        if (!noise_mode_sel)
        begin
            // Reduction: take a fraction of the noise away
            if (below)
                nr_sum = $signed({5'h00, y0}) - cut[12:0];
        end
        else
        begin
            // Sharpening: add a fraction of the detail back
            if (above)
                nr_sum = $signed({5'h00, y0}) + lift[12:0];
        end
    end

    wire [7:0] y_nr = sat8(nr_sum);

    // Contrast first, brightness setup after it
    wire [15:0] scaled = y_nr * LUMA_SCALE_VALUE;
    wire [8:0]  y_sc   = scaled[15:`SCALE_SHIFT];

    // Seven-bit two's complement setup, sign extended; the
    // negative half reaches below zero setup for -7.5 IRE
    wire signed [12:0] setup = {{6{brightness_value[6]}}, brightness_value};
    wire signed [12:0] y_sum = $signed({4'h0, y_sc}) + setup;

    // Hue offset in steps of 1/2048 turn about the zero code;
    // it steers the subcarrier only, so luma never sees it
    wire [7:0] hue_rel = hue_q - `HUE_ZERO;

    // History and counters advance on each consumed word
    always @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            y1_q   <= 8'h00;
            y2_q   <= 8'h00;
            y3_q   <= 8'h00;
            y4_q   <= 8'h00;
            hcnt_q <= 4'h0;
            vcnt_q <= 4'h0;
        end
        else if (take)
        begin
            y1_q   <= y0;
            y2_q   <= y1_q;
            y3_q   <= y2_q;
            y4_q   <= y3_q;
            hcnt_q <= hnow + 4'h1;
            vcnt_q <= vnow;
        end
    end

    // Output word register with its valid flag
    always @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            OUT_Y         <= 8'h00;
            OUT_C         <= 8'h00;
            OUT_HUE_PHASE <= 8'h00;
            OUT_ACTIVE    <= 1'b0;
            OUT_VALID     <= 1'b0;
        end
        else if (take)
        begin
            OUT_Y      <= sat8(y_sum);
            OUT_C      <= c0;
            OUT_ACTIVE <= act0;
            OUT_VALID  <= 1'b1;
            // Shift applies in active video only; burst keeps zero
            OUT_HUE_PHASE <= act0 ? hue_rel : 8'h00;
        end
        else if (OUT_READY)
        begin
            OUT_VALID <= 1'b0;
        end
    end

    // Sharpness response reaches the luma filter only in the
    // extended selection with its enable set; otherwise nominal
    always @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            SHARP_CODE <= `SHARP_NOMINAL;
            SHARP_ON   <= 1'b0;
        end
        else if ((LUMA_FILTER_SELECT == `LUMA_EXTENDED) && SHARPNESS_FILTER_ENABLE)
        begin
            SHARP_CODE <= sharpness_code;
            SHARP_ON   <= 1'b1;
        end
        else
        begin
            SHARP_CODE <= `SHARP_NOMINAL;
            SHARP_ON   <= 1'b0;
        end
    end

endmodule // picture_adjust_noise_reduce

`default_nettype wire

// ---- tb/picture_adjust_checker_sva.sv ----
// Checker of the picture adjust stage, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module picture_adjust_checker
(
    // Clock and reset
    input wire logic       REF_CLK,
    input wire logic       SYS_RST,
    // Control port
    input wire logic [5:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    // Mode inputs and outputs
    input wire logic [2:0] LUMA_FILTER_SELECT,
    input wire logic       SHARPNESS_FILTER_ENABLE,
    input wire logic [7:0] OUT_Y,
    input wire logic [7:0] OUT_HUE_PHASE,
    input wire logic       OUT_ACTIVE,
    input wire logic       OUT_VALID,
    input wire logic       OUT_READY,
    input wire logic       PIX_READY,
    input wire logic [3:0] SHARP_CODE,
    input wire logic       SHARP_ON
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    // Shadow hue and sharpness, rebuilt from observed writes
    logic [7:0] hue_q;
    logic [3:0] sharp_q;
    always @(posedge REF_CLK)
    begin
        if (SYS_RST)
        begin
            hue_q   <= 8'h80;
            sharp_q <= 4'h6;
        end
        else if (REG_WR && REG_ADDR == 6'h20)
            hue_q <= REG_WDATA;
        else if (REG_WR && REG_ADDR == 6'h22)
            sharp_q <= REG_WDATA[3:0];
    end
    // A write followed at once by a read returns the written byte
    property p_readback(a);
        (REG_WR && REG_ADDR == a) ##1 (REG_RD && !REG_WR && REG_ADDR == a) |=> REG_RDATA == $past(REG_WDATA, 2);
    endproperty
    chk_hue_readback: assert property (p_readback(6'h20))
        else $error("hue readback differs");
    chk_bright_readback: assert property (p_readback(6'h21))
        else $error("brightness readback differs");
    chk_sharp_readback: assert property (p_readback(6'h22))
        else $error("sharpness readback differs");
    chk_mode_readback: assert property (p_readback(6'h25))
        else $error("mode readback differs");
    chk_hue_phase: assert property (OUT_VALID |-> OUT_HUE_PHASE == (OUT_ACTIVE ? hue_q - 8'h80 : 8'h00))
        else $error("hue phase wrong");
    chk_hue_zero: assert property (hue_q == 8'h80 && OUT_VALID |-> OUT_HUE_PHASE == 8'h00)
        else $error("neutral hue not zero");
    chk_sharp_gate: assert property (!$past(SYS_RST) |-> SHARP_ON == ($past(LUMA_FILTER_SELECT) == 3'h4 && $past(SHARPNESS_FILTER_ENABLE)))
        else $error("sharpness gate wrong");
    chk_sharp_code: assert property (SHARP_ON && !$past(SYS_RST) |-> SHARP_CODE == $past(sharp_q))
        else $error("sharpness code wrong");
    chk_out_hold: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_Y) && $stable(OUT_HUE_PHASE))
        else $error("output word changed while stalled");
    // Main scenarios
    cov_active_word: cover property (OUT_VALID && OUT_READY && OUT_ACTIVE);
    cov_full: cover property (!PIX_READY);
    cov_sharp_on: cover property (SHARP_ON);
endmodule // picture_adjust_checker
bind picture_adjust_noise_reduce picture_adjust_checker u_chk
(
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .LUMA_FILTER_SELECT(LUMA_FILTER_SELECT),
    .SHARPNESS_FILTER_ENABLE(SHARPNESS_FILTER_ENABLE), .OUT_Y(OUT_Y), .OUT_HUE_PHASE(OUT_HUE_PHASE),
    .OUT_ACTIVE(OUT_ACTIVE), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .PIX_READY(PIX_READY),
    .SHARP_CODE(SHARP_CODE), .SHARP_ON(SHARP_ON)
);
`default_nettype wire

// ---- tb/pixel_source.sv ----
// Upstream pixel source model, one word per accepted handshake.
// Its tasks wait for a falling edge of clk before they drive the stream.
`timescale 1ns/100ps
`default_nettype none
module pixel_source
(
    // Clock
    input  wire logic       clk,
    // Stream towards the stage
    output var  logic [7:0] y,
    output var  logic [7:0] c,
    output var  logic       line,
    output var  logic       field,
    output var  logic       active,
    output var  logic       valid,
    input  wire logic       ready,
    // Raised when a word is never taken
    output var  logic       stuck
);
    initial
    begin
        {y, c, line, field, active, valid, stuck} = '0;
    end
    // Offer a word; ready only moves at rising edges, so it is read mid-cycle
    task send(input logic [7:0] ny, input logic [7:0] nc, input logic [2:0] flags);
        int n;
        begin
            @(negedge clk);
            {y, c, field, line, active, valid} = {ny, nc, flags, 1'b1};
            n = 0;
            #1;
            while (ready !== 1'b1 && n < 300)
            begin
                n++;
                @(negedge clk);
                #1;
            end
            if (n == 300)
                stuck = 1'b1;
            @(posedge clk);
        end
    endtask
    // Release the stream; y and c are inverted so no stale word is visible
    task idle();
        @(negedge clk);
        valid = 1'b0;
        y = ~y;
        c = ~c;
    endtask
endmodule // pixel_source
`default_nettype wire

// ---- tb/tb_picture_adjust_noise_reduce.sv ----
// Self-checking bench of the picture adjust and noise reduction stage.
// Assumes the design, the checker and the source model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("Error at %0t: got %h, expected %h", $time, g, e); end end
module tb_picture_adjust_noise_reduce;
    logic       clk, sys_rst, wr_s, rd_s, en, out_ready, stall, rd_seen;
    logic [5:0] addr;
    logic [7:0] wdata, cval, prev_y, p2, p3, p4;
    logic [2:0] lsel;
    wire  [7:0] rdata, py, pc, oy, oc, oh;
    wire        pl, pf, pa, pv, pr, oa, ov, son, stuck;
    wire  [3:0] scode;
    int         failures, compares, gain, thr, mode, i, k, n, hq, vq, ofs, blk, wid, sel;
    logic [7:0] hue, bright;
    logic [24:0] pq[$];
    logic [24:0] pexp;
    logic [7:0]  rq[$];
    logic [7:0]  rexp;
    logic [31:0] seed;
    logic [31:0] r;
    // Fixed-seed shift register for stimulus
    function logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // Expected output word from the luma coring, scaling and setup chain
    function logic [24:0] exp_word(input logic [7:0] yy, input logic [7:0] cc, input logic act, input logic ln,
                                   input logic fd);
        int b, ab, g, v, h, vv, sz, hw;
        begin
            // Grid place: pixels since line start, lines since field start
            h = ln ? 0 : hq;
            vv = fd ? 0 : (ln ? vq + 1 : vq);
            hq = (h + 1) % 16;
            vq = vv % 16;
            sz = blk ? 16 : 8;
            hw = wid ? 2 : 1;
            h = (h + ofs) % sz;
            vv = vv % sz;
            // Border strip takes the low nibble, block inside the high one
            g = (h < hw || h >= sz - hw || vv < hw || vv >= sz - hw) ? gain % 16 : gain / 16;
            g = g > 8 ? 8 : g;
            case (sel)
                1: b = int'(yy) - (int'(prev_y) + int'(p2)) / 2;
                2: b = int'(yy) - (int'(prev_y) + int'(p2) + int'(p3) + int'(p4)) / 4;
                default: b = int'(yy) - int'(prev_y);
            endcase
            ab = b < 0 ? -b : b;
            v = yy;
            // Kept in int so the shifts stay arithmetic on negative bands
            if (mode == 0 && ab < thr)
                v = v - ((b * g) >>> 3);
            else if (mode == 1 && ab > thr)
                v = v + ((b * g) >>> 4);
            v = v < 0 ? 0 : (v > 255 ? 255 : v);
            v = ((v * int'(cval)) >>> 7) + $signed(bright[6:0]);
            v = v < 0 ? 0 : (v > 255 ? 255 : v);
            {p4, p3, p2, prev_y} = {p3, p2, prev_y, yy};
            return {act, v[7:0], cc, act ? hue - 8'h80 : 8'h00};
        end
    endfunction
    picture_adjust_noise_reduce dut
    (
        .REF_CLK(clk), .SYS_RST(sys_rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
        .REG_RDATA(rdata), .LUMA_FILTER_SELECT(lsel), .SHARPNESS_FILTER_ENABLE(en), .LUMA_SCALE_VALUE(cval),
        .PIX_Y(py), .PIX_C(pc), .PIX_LINE(pl), .PIX_FIELD(pf), .PIX_ACTIVE(pa), .PIX_VALID(pv), .PIX_READY(pr),
        .OUT_Y(oy), .OUT_C(oc), .OUT_HUE_PHASE(oh), .OUT_ACTIVE(oa), .OUT_VALID(ov), .OUT_READY(out_ready),
        .SHARP_CODE(scode), .SHARP_ON(son)
    );
    pixel_source src
    (
        .clk(clk), .y(py), .c(pc), .line(pl), .field(pf), .active(pa), .valid(pv), .ready(pr), .stuck(stuck)
    );
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Far side takes words at random, unless held off
    always @(negedge clk)
        out_ready <= !stall && ((rnd() & 32'h3) != 0);
    // Result watcher: oldest note against each result that appears
    always @(posedge clk)
    begin
        // Notes are taken off once, before the compare that uses them
        if (rd_seen)
        begin
            rexp = rq.pop_front();
            `CHK(rdata, rexp)
        end
        rd_seen <= rd_s;
        if (ov === 1'b1 && out_ready)
        begin
            pexp = pq.size() ? pq.pop_front() : 25'hx;
            `CHK({oa, oy, oc, oh}, pexp)
        end
    end
    always @(posedge stuck)
    begin
        failures++;
        give_verdict();
    end
    // Write without a gap so a read may follow at once
    task wr(input logic [5:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(negedge clk);
        wr_s = 1'b0;
    endtask
    task rd(input logic [5:0] a, input logic [7:0] e);
        addr = a;
        rd_s = 1'b1;
        rq.push_back(e);
        @(negedge clk);
        rd_s = 1'b0;
        @(negedge clk);
    endtask
    task wrd(input logic [5:0] a, input logic [7:0] d);
        wr(a, d);
        rd(a, d);
    endtask
    // Bounded wait until every noted word has come out
    task drain();
        n = 0;
        while ((pq.size() != 0 || ov === 1'b1) && n < 500)
        begin
            n++;
            @(negedge clk);
        end
        if (n == 500)
        begin
            failures++;
            give_verdict();
        end
    endtask
    task give_verdict();
        $display("Counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Configuration table: hue, brightness (clear of 3f..44), gains, threshold, mode
    logic [7:0] t_hue[5] = '{8'h97, 8'h69, 8'h00, 8'hff, 8'h80};
    logic [7:0] t_br[5]  = '{8'h00, 8'h72, 8'h1e, 8'h0f, 8'h71};
    logic [7:0] t_gn[5]  = '{8'h00, 8'h00, 8'h88, 8'h88, 8'h4c};
    logic [5:0] t_th[5]  = '{6'h00, 6'h00, 6'h3f, 6'h10, 6'h20};
    logic       t_md[5]  = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [2:0] t_sl[5]  = '{3'h0, 3'h5, 3'h2, 3'h1, 3'h7};
    initial
    begin
        {wr_s, rd_s, en, stall, rd_seen, addr, wdata, lsel, prev_y, p2, p3, p4, hue, bright} = '0;
        {failures, compares, gain, thr, mode} = '0;
        cval = 8'h80;
        out_ready = 1'b0;
        seed = 32'h6d19c6d8;
        sys_rst = 1'b1;
        hue = 8'h80;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        rd(6'h20, 8'h80);
        rd(6'h22, 8'h06);
        for (i = 1; i < 6; i++)
            if (i != 2)
                rd(6'h20 + i[5:0], 8'h00);
        wr(6'h30, 8'h5a); // unmapped place reads as zero
        rd(6'h30, 8'h00);
        $display("Test register reset done");
        for (i = 0; i < 16; i++)
        begin
            lsel = i[3:1];
            en = i[0];
            repeat (2) @(negedge clk);
            `CHK(son, (i[3:1] == 3'h4 && i[0]))
        end
        // Extended selection with enable, so the written code reaches the output
        lsel = 3'h4;
        en = 1'b1;
        for (i = 0; i <= 12; i += 6)
        begin
            wrd(6'h22, {4'h0, i[3:0]});
            @(negedge clk);
            `CHK(scode, i[3:0])
        end
        $display("Test sharpness done");
        for (k = 0; k < 5; k++)
        begin
            hue = t_hue[k];
            bright = t_br[k];
            gain = t_gn[k];
            thr = t_th[k];
            mode = t_md[k];
            r = rnd();
            ofs = r[11:8];
            blk = r[7];
            wid = r[6];
            sel = t_sl[k];
            wrd(6'h20, hue);
            wrd(6'h21, bright);
            wrd(6'h23, t_gn[k]);
            wrd(6'h24, {r[7:6], t_th[k]});
            wrd(6'h25, {r[11:8], t_md[k], t_sl[k]});
            cval = rnd() % 193;
            for (i = 0; i < 40; i++)
            begin
                r = rnd();
                pq.push_back(exp_word(r[7:0], r[15:8], r[16], i % 16 == 0, i == 0));
                src.send(r[7:0], r[15:8], {i == 0, i % 16 == 0, r[16]});
                if (r[21:20] == 2'h0)
                    src.idle();
            end
            src.idle();
            drain();
            $display("Test stream config %0d done", k);
        end
        stall = 1'b1;
        @(negedge clk);
        @(negedge clk);
        for (i = 0; i < 17; i++)
        begin
            r = rnd();
            pq.push_back(exp_word(r[7:0], r[15:8], 1'b1, 1'b0, 1'b0));
            src.send(r[7:0], r[15:8], 3'h1);
        end
        @(negedge clk);
        #1;
        `CHK(pr, 1'b0)
        src.idle();
        stall = 1'b0;
        drain();
        $display("Test buffer fill done");
        give_verdict();
    end
endmodule // tb_picture_adjust_noise_reduce
`default_nettype wire
